// ===== hw/sfpi_flash.sv
// serial flash pin interface: pin sync, frame shifter, receive fifo, wishbone registers
//
// Functional notes
// - deselected: all data outputs floated
// - deselected and idle means standby
// - select low makes device active
// - commands ignored until first select fall
// - input bits captured on sck rise
// - output bits change on sck fall
// - single line input comes from io0
// - dual/quad read: io0 becomes output bit0
// - io0 ignored while deselected
// - dual read: io1 carries bit1
// - write protect low blocks status writes
// - quad enable frees io2 from protect
// - 65536 pages of 256 bytes
// - page program takes at most 256 bytes
// - erase aligned 4k, 32k, 64k, chip
// - pause ignores sck, floats outputs
`timescale 1ns/1ns
`include "sfpi_cfg.svh"

// ****************************************
// receive fifo
// ****************************************
module sfpi_fifo #(
    parameter int W = 9,
    parameter int D = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    input  wire logic [W-1:0] in_data_i,
    output logic              out_valid_o,
    input  wire logic         out_ready_i,
    output logic [W-1:0]      out_data_o
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = D[AW:0];

    logic [W-1:0]  mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   cnt;
    logic          push;
    logic          pop;

    assign in_ready_o  = (cnt != FULL);
    assign out_valid_o = (cnt != '0);
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;
    assign out_data_o  = mem[rd_ptr];

    // depth must be a power of two: pointers wrap by overflow
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            cnt    <= '0;
        end else if (ce_i) begin
            if (push) begin
                mem[wr_ptr] <= in_data_i;
                wr_ptr      <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            case ({push, pop})
                2'b10:   cnt <= cnt + 1'b1;
                2'b01:   cnt <= cnt - 1'b1;
                default: cnt <= cnt;
            endcase
        end
    end
endmodule : sfpi_fifo

// ****************************************
// top
// ****************************************
module sfpi_flash (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        sck_i,
    input  wire logic        cs_n_i,
    input  wire logic [3:0]  io_i,
    output logic [3:0]       io_o,
    output logic [3:0]       io_oe_o,
    output logic             standby_o,
    output logic             active_o
);
    import sfpi_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    // select bit resets low so that a select held low from reset
    // does not fake the first falling edge
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic [5:0] pin_dly;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta <= 6'h1F;
            pin_sync <= 6'h1F;
            pin_dly  <= 6'h1F;
        end else if (ce_i) begin
            pin_meta <= {cs_n_i, sck_i, io_i};
            pin_sync <= pin_meta;
            pin_dly  <= pin_sync;
        end
    end

    logic       cs_n_s;
    logic       sck_s;
    logic [3:0] io_s;
    logic       sck_rise;
    logic       sck_fall;
    logic       cs_fall;

    assign cs_n_s   = pin_sync[5];
    assign sck_s    = pin_sync[4];
    assign io_s     = pin_sync[3:0];
    assign sck_rise = pin_sync[4] & ~pin_dly[4];
    assign sck_fall = ~pin_sync[4] & pin_dly[4];
    assign cs_fall  = ~pin_sync[5] & pin_dly[5];

    // ****************************************
    // registers
    // ****************************************
    logic [5:0]  ctrl;
    logic [9:2]  sreg;
    logic        qe;
    logic        hw_prot;
    logic [1:0]  out_wid;
    logic        drive;
    logic        busy;

    assign busy    = ctrl[`SFPI_CTRL_BUSY];
    assign out_wid = ctrl[`SFPI_CTRL_WID +: 2];
    assign drive   = ctrl[`SFPI_CTRL_DRIVE];
    assign qe      = sreg[`SFPI_SR_QE];
    assign hw_prot = ~qe & ~io_s[2];

    // ****************************************
    // frame state
    // ****************************************
    sfpi_state_e st;
    sfpi_state_e next_st;
    logic        hold_req;
    logic        go;

    assign hold_req = ~qe & ~io_s[3];
    assign go       = (st == SFPI_ACTIVE) & ~cs_n_s;

    always_comb begin
        next_st = st;
        case (st)
            SFPI_LOCKED: begin
                if (cs_fall) begin
                    next_st = SFPI_ACTIVE;
                end
            end
            SFPI_IDLE: begin
                if (cs_fall) begin
                    next_st = SFPI_ACTIVE;
                end
            end
            SFPI_ACTIVE: begin
                if (cs_n_s) begin
                    next_st = SFPI_IDLE;
                end else if (hold_req & ~sck_s) begin
                    next_st = SFPI_PAUSE;
                end
            end
            SFPI_PAUSE: begin
                if (cs_n_s) begin
                    next_st = SFPI_IDLE;
                end else if (~hold_req) begin
                    next_st = SFPI_ACTIVE;
                end
            end
            default: next_st = SFPI_LOCKED;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= SFPI_LOCKED;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign standby_o = cs_n_s & ~busy;
    assign active_o  = (st == SFPI_ACTIVE) | (st == SFPI_PAUSE);

    // ****************************************
    // input shifter
    // ****************************************
    logic [6:0]  rx_sh;
    logic [2:0]  bit_cnt;
    logic [2:0]  byte_cnt;
    logic [8:0]  data_cnt;
    logic [23:0] addr;
    logic        rose_seen;
    logic        byte_done;
    logic [7:0]  rx_byte;
    logic        take;

    assign byte_done = sck_rise & go & (bit_cnt == 3'h7);
    assign rx_byte   = {rx_sh, io_s[0]};
    assign take      = (byte_cnt != 3'h4) | (data_cnt != `SFPI_PAGE_BYTES);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_sh     <= '0;
            bit_cnt   <= '0;
            byte_cnt  <= '0;
            data_cnt  <= '0;
            addr      <= '0;
            rose_seen <= 1'b0;
        end else if (ce_i) begin
            if (st != SFPI_ACTIVE && st != SFPI_PAUSE) begin
                bit_cnt   <= '0;
                byte_cnt  <= '0;
                data_cnt  <= '0;
                rose_seen <= 1'b0;
            end else if (sck_rise & go) begin
                rx_sh     <= rx_byte[6:0];
                bit_cnt   <= bit_cnt + 1'b1;
                rose_seen <= rose_seen | byte_done;
                if (byte_done) begin
                    if (byte_cnt != 3'h4) begin
                        byte_cnt <= byte_cnt + 1'b1;
                    end
                    if (byte_cnt != 3'h0 && byte_cnt != 3'h4) begin
                        addr <= {addr[15:0], rx_byte};
                    end
                    if (byte_cnt == 3'h4 && take) begin
                        data_cnt <= data_cnt + 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************
    // hand-off into the fifo
    // ****************************************
    // link cannot stall: one byte waits here while the fifo is full;
    // a second byte meanwhile is an overflow
    logic       hold_v;
    logic [8:0] hold_d;
    logic       f_in_ready;
    logic       f_out_valid;
    logic [8:0] f_out_data;
    logic       f_pop;
    logic       new_byte;
    logic       ovf_set;
    logic       pg_set;

    assign new_byte = byte_done & take;
    assign ovf_set  = new_byte & hold_v & ~f_in_ready;
    assign pg_set   = byte_done & ~take;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_v <= 1'b0;
            hold_d <= '0;
        end else if (ce_i) begin
            if (new_byte & ~ovf_set) begin
                hold_v <= 1'b1;
                hold_d <= {(byte_cnt == 3'h0), rx_byte};
            end else if (hold_v & f_in_ready) begin
                hold_v <= 1'b0;
            end
        end
    end

    sfpi_fifo #(
        .W (`SFPI_FIFO_WIDTH),
        .D (`SFPI_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_valid_i  (hold_v),
        .in_ready_o  (f_in_ready),
        .in_data_i   (hold_d),
        .out_valid_o (f_out_valid),
        .out_ready_i (f_pop),
        .out_data_o  (f_out_data)
    );

    // ****************************************
    // output shifter
    // ****************************************
    logic [7:0] tx_buf;
    logic [7:0] tx_sh;
    logic [3:0] tx_left;
    logic [7:0] tx_word;
    logic [3:0] tx_step;
    logic       tx_shift;
    logic       tx_load;

    // no shift before the first whole byte, so replies align to bytes
    assign tx_shift = sck_fall & go & rose_seen & drive;
    assign tx_load  = tx_shift & (tx_left == 4'h0);
    assign tx_word  = (tx_left == 4'h0) ? tx_buf : tx_sh;

    always_comb begin
        case (out_wid)
            SFPI_W2: tx_step = 4'h2;
            SFPI_W4: tx_step = 4'h4;
            default: tx_step = 4'h1;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_sh   <= '0;
            tx_left <= '0;
            io_o    <= '0;
        end else if (ce_i) begin
            if (st != SFPI_ACTIVE && st != SFPI_PAUSE) begin
                tx_left <= '0;
                io_o    <= '0;
            end else if (tx_shift) begin
                tx_sh   <= tx_word << tx_step;
                tx_left <= ((tx_left == 4'h0) ? 4'h8 : tx_left) - tx_step;
                case (out_wid)
                    SFPI_W2: io_o <= {2'b00, tx_word[7:6]};
                    SFPI_W4: io_o <= tx_word[7:4];
                    default: io_o <= {2'b00, tx_word[7], 1'b0};
                endcase
            end
        end
    end

    // quad needs the enable bit: without it io2/io3 keep protect and pause
    always_comb begin
        io_oe_o = 4'h0;
        if (go & drive) begin
            case (out_wid)
                SFPI_W2: io_oe_o = 4'h3;
                SFPI_W4: io_oe_o = qe ? 4'hF : 4'h3;
                default: io_oe_o = 4'h2;
            endcase
        end
    end

    // ****************************************
    // address decode helpers
    // ****************************************
    logic [23:0] erase_base;

    always_comb begin
        case (ctrl[`SFPI_CTRL_ESZ +: 2])
            2'h0:    erase_base = addr & `SFPI_MASK_4K;
            2'h1:    erase_base = addr & `SFPI_MASK_32K;
            2'h2:    erase_base = addr & `SFPI_MASK_64K;
            default: erase_base = 24'h000000;
        endcase
    end

    // ****************************************
    // wishbone slave
    // ****************************************
    logic req;
    logic wr;
    logic ovf;
    logic pgfull;
    logic txfull;
    logic st_clr;

    assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr     = req & wb_we_i;
    assign f_pop  = req & ~wb_we_i & (wb_adr_i == `SFPI_A_RXDATA) & f_out_valid;
    assign st_clr = wr & (wb_adr_i == `SFPI_A_STAT) & wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= `SFPI_CTRL_RST;
            sreg <= `SFPI_SR_RST;
        end else if (ce_i) begin
            if (wr & (wb_adr_i == `SFPI_A_CTRL) & wb_sel_i[0]) begin
                ctrl <= wb_dat_i[5:0];
            end
            if (wr & (wb_adr_i == `SFPI_A_SREG) & ~hw_prot) begin
                if (wb_sel_i[0]) begin
                    sreg[7:2] <= wb_dat_i[7:2];
                end
                if (wb_sel_i[1]) begin
                    sreg[9:8] <= wb_dat_i[9:8];
                end
            end
        end
    end

    // sticky flags: a set in the same cycle as a clear wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovf    <= 1'b0;
            pgfull <= 1'b0;
            txfull <= 1'b0;
            tx_buf <= '0;
        end else if (ce_i) begin
            if (ovf_set) begin
                ovf <= 1'b1;
            end else if (st_clr & wb_dat_i[`SFPI_ST_OVF]) begin
                ovf <= 1'b0;
            end
            if (pg_set) begin
                pgfull <= 1'b1;
            end else if (st_clr & wb_dat_i[`SFPI_ST_PGFULL]) begin
                pgfull <= 1'b0;
            end
            if (wr & (wb_adr_i == `SFPI_A_TXDATA) & wb_sel_i[0]) begin
                tx_buf <= wb_dat_i[7:0];
                txfull <= 1'b1;
            end else if (tx_load) begin
                txfull <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (ce_i) begin
            if (req & ~wb_we_i) begin
                case (wb_adr_i)
                    `SFPI_A_CTRL:   wb_dat_o <= {26'h0, ctrl};
                    `SFPI_A_SREG:   wb_dat_o <= {22'h0, sreg, 2'b00};
                    `SFPI_A_STAT:   wb_dat_o <= {24'h0, pgfull, txfull, ovf, hw_prot,
                                                 (st == SFPI_PAUSE), standby_o,
                                                 (st != SFPI_LOCKED), ~cs_n_s};
                    `SFPI_A_RXDATA: wb_dat_o <= {22'h0, f_out_valid, f_out_data};
                    `SFPI_A_TXDATA: wb_dat_o <= {24'h0, tx_buf};
                    `SFPI_A_ADDR:   wb_dat_o <= {8'h0, addr};
                    `SFPI_A_PAGE:   wb_dat_o <= {8'h0, addr[23:8], addr[7:0]};
                    `SFPI_A_ERASE:  wb_dat_o <= {8'h0, erase_base};
                    default:        wb_dat_o <= 32'h0;
                endcase
            end else begin
                wb_dat_o <= 32'h0;
            end
        end
    end
endmodule : sfpi_flash

// ===== include/sfpi_cfg.svh
// register map, field positions, reset values and sizes of the flash pin interface
`ifndef SFPI_CFG_SVH
`define SFPI_CFG_SVH

// ****************************************
// register byte offsets
// ****************************************
`define SFPI_A_CTRL      8'h00
`define SFPI_A_SREG      8'h04
`define SFPI_A_STAT      8'h08
`define SFPI_A_RXDATA    8'h0C
`define SFPI_A_TXDATA    8'h10
`define SFPI_A_ADDR      8'h14
`define SFPI_A_PAGE      8'h18
`define SFPI_A_ERASE     8'h1C

// ****************************************
// control fields
// ****************************************
`define SFPI_CTRL_BUSY   0
`define SFPI_CTRL_WID    1
`define SFPI_CTRL_DRIVE  3
`define SFPI_CTRL_ESZ    4
`define SFPI_CTRL_RST    6'h00

// ****************************************
// flash status image fields
// ****************************************
`define SFPI_SR_BP       2
`define SFPI_SR_TB       5
`define SFPI_SR_SEC      6
`define SFPI_SR_SRP      7
`define SFPI_SR_QE       9
`define SFPI_SR_RST      8'h00

// ****************************************
// status fields
// ****************************************
`define SFPI_ST_SEL      0
`define SFPI_ST_ARMED    1
`define SFPI_ST_STBY     2
`define SFPI_ST_PAUSE    3
`define SFPI_ST_WPROT    4
`define SFPI_ST_OVF      5
`define SFPI_ST_TXFULL   6
`define SFPI_ST_PGFULL   7

// ****************************************
// array organisation
// ****************************************
`define SFPI_PAGE_BYTES  9'h100
`define SFPI_PAGE_COUNT  17'h10000
`define SFPI_MASK_4K     24'hFFF000
`define SFPI_MASK_32K    24'hFF8000
`define SFPI_MASK_64K    24'hFF0000
`define SFPI_FIFO_DEPTH  8
`define SFPI_FIFO_WIDTH  9

`endif

// ===== include/sfpi_pkg.sv
// types shared by the flash pin interface
package sfpi_pkg;

    typedef enum logic [1:0] {
        SFPI_LOCKED = 2'b00,
        SFPI_IDLE   = 2'b01,
        SFPI_ACTIVE = 2'b11,
        SFPI_PAUSE  = 2'b10
    } sfpi_state_e;

    typedef enum logic [1:0] {
        SFPI_W1 = 2'h0,
        SFPI_W2 = 2'h1,
        SFPI_W4 = 2'h2
    } sfpi_width_e;

endpackage : sfpi_pkg

// ===== test/sfpi_flash_assertions.sv
// port-level checker of the flash pin interface
`timescale 1ns/1ns
module sfpi_flash_assertions (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        sck_i,
    input wire logic        cs_n_i,
    input wire logic [3:0]  io_o,
    input wire logic [3:0]  io_oe_o,
    input wire logic        standby_o,
    input wire logic        active_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic armed;
    // raw select fall: looser than the synced view
    always_ff @(posedge clk_i) begin
        if (rst_i) armed <= 1'b0;
        else if ($fell(cs_n_i)) armed <= 1'b1;
    end
    float_desel_a: assert property (cs_n_i [*5] |-> io_oe_o == 4'h0)
        else $error("driven while deselected");
    busy_sel_a: assert property (!cs_n_i [*5] |-> !standby_o)
        else $error("standby while selected");
    wake_sel_a: assert property ((armed && !cs_n_i) [*6] |-> active_o)
        else $error("not active while selected");
    locked_start_a: assert property (active_o |-> armed)
        else $error("active before any select fall");
    out_fall_a: assert property ($changed(io_o) && !cs_n_i |-> !$past(sck_i, 2))
        else $error("output change off a clock fall");
    dual_lanes_a: assert property (io_oe_o[0] |-> io_oe_o[1])
        else $error("bit0 lane without bit1 lane");
    quad_lanes_a: assert property (io_oe_o[3] |-> io_oe_o[2] && io_oe_o[0])
        else $error("quad lanes incomplete");
    ack_pulse_a: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
endmodule : sfpi_flash_assertions

bind sfpi_flash sfpi_flash_assertions chk (.*);

// ===== test/sfpi_flash_bench.sv
// self-checking bench of the flash pin interface
`timescale 1ns/1ns
`include "sfpi_cfg.svh"
module sfpi_flash_bench;
    import sfpi_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic        wb_we_i  = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, sck, cs_n, standby_o, active_o;
    logic [3:0]  io, io_o, io_oe_o;
    int          mismatches   = 0;
    int          total_checks = 0;
    sfpi_flash DUT (.ce_i(1'b1), .sck_i(sck), .cs_n_i(cs_n), .io_i(io), .*);
    sfpi_host_model host (.clk_i(clk_i), .io_o_i(io_o), .io_oe_i(io_oe_o), .sck_o(sck),
        .cs_n_o(cs_n), .io_o(io));
    initial forever #5 clk_i = ~clk_i;
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        wb(1'b1, a, d, s, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        wb(1'b0, a, 32'h0, 4'hF, q);
    endtask : rd
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        rd(a, q);
        chk(n, e, q);
    endtask : rdc
    task automatic drain(output int n);
        logic [31:0] q;
        n = -1;
        do begin
            n++;
            rd(`SFPI_A_RXDATA, q);
        end while (q[9] === 1'b1 && n < 12);
    endtask : drain
    task automatic frame(input logic m, input logic [7:0] b0, input logic [7:0] b1,
                         input int w, output logic [7:0] r);
        host.sel(m);
        host.xfer(b0, 1, r);
        host.xfer(b1, w, r);
        host.desel();
    endtask : frame
    task automatic toggle(input int n);
        repeat (n) begin
            host.mosi  <= 1'b1;
            host.sck_o <= 1'b1;
            host.half();
            host.sck_o <= 1'b0;
            host.half();
        end
    endtask : toggle
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_lock;
        logic [7:0] r;
        host.xfer(8'hA5, 1, r);
        host.desel();
        rdc("rx locked", `SFPI_A_RXDATA, 32'h0);
        rdc("ctrl reset", `SFPI_A_CTRL, 32'h0);
        rdc("sreg reset", `SFPI_A_SREG, 32'h0);
        wr(8'h20, 32'hFFFFFFFF, 4'hF);
        rdc("unmapped", 8'h20, 32'h0);
        $display("t_lock done");
    endtask : t_lock
    task automatic t_rx;
        logic [7:0] r;
        for (int m = 0; m < 2; m++) begin
            frame(m[0], 8'hA5 ^ 8'(m), 8'h3C, 1, r);
            rdc("rx first", `SFPI_A_RXDATA, 32'h3A5 ^ 32'(m));
            rdc("rx second", `SFPI_A_RXDATA, 32'h23C);
        end
        $display("t_rx done");
    endtask : t_rx
    task automatic t_desel;
        int n;
        wr(`SFPI_A_CTRL, 32'h8, 4'h1);
        toggle(8);
        chk("oe idle", 32'h0, 32'(io_oe_o));
        chk("standby", 32'h1, 32'(standby_o));
        chk("active idle", 32'h0, 32'(active_o));
        drain(n);
        chk("rx ignored", 32'h0, 32'(n));
        host.sel(1'b0);
        chk("active sel", 32'h1, 32'(active_o));
        chk("standby sel", 32'h0, 32'(standby_o));
        host.desel();
        $display("t_desel done");
    endtask : t_desel
    task automatic t_pause;
        logic [7:0] r;
        host.sel(1'b0);
        host.xfer(8'h12, 1, r);
        host.sck_o <= 1'b0;
        host.half();
        host.hold_n <= 1'b0;
        host.half();
        toggle(3);
        chk("oe paused", 32'h0, 32'(io_oe_o));
        host.hold_n <= 1'b1;
        host.half();
        host.xfer(8'h34, 1, r);
        host.desel();
        rdc("rx pre pause", `SFPI_A_RXDATA, 32'h312);
        rdc("rx post pause", `SFPI_A_RXDATA, 32'h234);
        wr(`SFPI_A_CTRL, 32'h0, 4'h1);
        $display("t_pause done");
    endtask : t_pause
    task automatic t_wp;
        host.wp_n <= 1'b0;
        host.half();
        wr(`SFPI_A_SREG, 32'h1C, 4'h1);
        rdc("sreg locked", `SFPI_A_SREG, 32'h0);
        host.wp_n <= 1'b1;
        host.half();
        wr(`SFPI_A_SREG, 32'h200, 4'h2);
        host.wp_n <= 1'b0;
        host.half();
        wr(`SFPI_A_SREG, 32'h21C, 4'h3);
        rdc("sreg quad", `SFPI_A_SREG, 32'h21C);
        host.wp_n <= 1'b1;
        $display("t_wp done");
    endtask : t_wp
    task automatic t_tx;
        logic [7:0] tx[3] = '{8'hC6, 8'h9B, 8'h5E};
        logic [7:0] r;
        int         n;
        for (int k = 0; k < 3; k++) begin
            wr(`SFPI_A_CTRL, 32'h8 | 32'(k << 1), 4'h1);
            wr(`SFPI_A_TXDATA, 32'(tx[k]), 4'h1);
            frame(1'b0, 8'h0B, 8'h00, 1 << k, r);
            chk("tx byte", 32'(tx[k]), 32'(r));
            drain(n);
        end
        wr(`SFPI_A_CTRL, 32'h0, 4'h1);
        $display("t_tx done");
    endtask : t_tx
    task automatic t_fifo;
        logic [7:0]  r;
        logic [31:0] q;
        int          n;
        host.sel(1'b0);
        for (int i = 0; i < 11; i++) host.xfer(8'h40 + 8'(i), 1, r);
        host.desel();
        rd(`SFPI_A_STAT, q);
        chk("ovf", 32'h1, 32'(q[5]));
        rdc("rx oldest", `SFPI_A_RXDATA, 32'h340);
        drain(n);
        chk("fifo depth", `SFPI_FIFO_DEPTH, n);
        wr(`SFPI_A_STAT, 32'h20, 4'h1);
        rd(`SFPI_A_STAT, q);
        chk("ovf clear", 32'h0, 32'(q[5]));
        $display("t_fifo done");
    endtask : t_fifo
    task automatic t_page;
        logic [23:0] m[4] = '{`SFPI_MASK_4K, `SFPI_MASK_32K, `SFPI_MASK_64K, 24'h0};
        logic [7:0]  r;
        logic [31:0] q;
        int          n;
        host.sel(1'b0);
        foreach (m[i]) host.xfer(8'h02 + 8'(i * 8'h10), 1, r);
        repeat (256) host.xfer(8'h00, 1, r);
        rd(`SFPI_A_STAT, q);
        chk("page not full", 32'h0, 32'(q[7]));
        host.xfer(8'h00, 1, r);
        rd(`SFPI_A_STAT, q);
        chk("page full", 32'h1, 32'(q[7]));
        host.desel();
        rdc("addr", `SFPI_A_ADDR, 32'h122232);
        rdc("page", `SFPI_A_PAGE, 32'h122232);
        for (int k = 0; k < 4; k++) begin
            wr(`SFPI_A_CTRL, 32'(k << 4), 4'h1);
            rdc("erase base", `SFPI_A_ERASE, 32'(24'h122232 & m[k]));
        end
        wr(`SFPI_A_CTRL, 32'h0, 4'h1);
        wr(`SFPI_A_STAT, 32'hA0, 4'h1);
        drain(n);
        $display("t_page done");
    endtask : t_page
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_lock();
        t_rx();
        t_desel();
        t_pause();
        t_page();
        t_fifo();
        t_wp();
        t_tx();
        test_done();
    end
    // whole run needs about 19000 cycles
    initial begin
        #1000000;
        mismatches++;
        test_done();
    end
endmodule : sfpi_flash_bench

// ===== test/sfpi_host_model.sv
// host controller model: select, link clock and data lines
`timescale 1ns/1ns
module sfpi_host_model (
    input  wire logic       clk_i,
    input  wire logic [3:0] io_o_i,
    input  wire logic [3:0] io_oe_i,
    output logic            sck_o,
    output logic            cs_n_o,
    output logic [3:0]      io_o
);
    logic       mosi   = 1'b0;
    logic       wp_n   = 1'b1;
    logic       hold_n = 1'b1;
    logic       idle   = 1'b0;
    logic       last   = 1'b0;
    // powered up selected: no select fall at first
    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b0;
    end
    // released serial out toggles: a stale bit must never pass for data
    always_ff @(posedge clk_i) last <= io_o[1];
    assign io_o = (io_oe_i & io_o_i) | (~io_oe_i & {hold_n, wp_n, ~last, mosi});
    task automatic half;
        repeat (4) @(posedge clk_i);
    endtask : half
    task automatic sel(input logic m);
        idle  <= m;
        sck_o <= m;
        half();
        cs_n_o <= 1'b0;
        half();
    endtask : sel
    task automatic desel;
        sck_o <= idle;
        half();
        cs_n_o <= 1'b1;
        half();
    endtask : desel
    // w lines per rise: drive on the fall, sample reply before the rise
    task automatic xfer(input logic [7:0] tx, input int w, output logic [7:0] rx);
        for (int i = 7; i >= 0; i -= w) begin
            sck_o <= 1'b0;
            mosi  <= tx[i];
            half();
            if (w == 1) rx = {rx[6:0], io_o[1]};
            else if (w == 2) rx = {rx[5:0], io_o[1:0]};
            else rx = {rx[3:0], io_o};
            sck_o <= 1'b1;
            half();
        end
    endtask : xfer
endmodule : sfpi_host_model
